// >>> verilog/ppmc_pkg.sv
// Shared constants, types and register map of the port pin and mode control block
package ppmc_pkg;

  // ****************************************************************
  // Port set geometry
  // ****************************************************************
  localparam int PPMC_NPORT = 16;
  localparam int PPMC_NPIN  = 128;

  localparam logic [3:0] PPMC_P0 = 4'h0;
  localparam logic [3:0] PPMC_P2 = 4'h2;
  localparam logic [3:0] PPMC_P5 = 4'h5;
  localparam logic [3:0] PPMC_P7 = 4'h7;
  localparam logic [3:0] PPMC_PA = 4'hd;
  localparam logic [3:0] PPMC_PB = 4'he;
  localparam logic [3:0] PPMC_PX = 4'hf;

  // Index order [15]..[0]: X, B, A, 12 .. 0
  localparam logic [15:0][7:0] PPMC_IMPL = {8'he0, {15{8'hff}}};
  localparam logic [15:0][7:0] PPMC_INONLY = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam logic [15:0][7:0] PPMC_FSEL_WR = {
    8'he0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfc, 8'hff, 8'hff};
  localparam logic [15:0][7:0] PPMC_FSEL_FIX1 = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  // Ports that come up as external bus pins outside single-chip mode 0; port 5 keeps its select in mode 3
  localparam logic [15:0][7:0] PPMC_BUS_INIT = {
    8'he0, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
    8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

  // ****************************************************************
  // Register map (byte addresses, one byte register every two bytes)
  // ****************************************************************
  localparam logic [31:0] PPMC_DATA_BASE = 32'hfffff000;
  localparam logic [31:0] PPMC_DIR_BASE  = 32'hfffff020;
  localparam logic [31:0] PPMC_FSEL_BASE = 32'hfffff040;
  localparam logic [31:0] PPMC_ALT0_ADDR = 32'hfffff580;

  localparam logic [7:0] PPMC_LATCH_RST = 8'h00;
  localparam logic [7:0] PPMC_DIR_RST   = 8'hff;
  localparam logic [7:0] PPMC_ALT_RST   = 8'h00;
  localparam logic [7:0] PPMC_ALT_WR    = 8'hf0;

  // ****************************************************************
  // Bit positions of port 0 and port X functions
  // ****************************************************************
  localparam int PPMC_B_TMR_A  = 0;
  localparam int PPMC_B_TMR_B  = 1;
  localparam int PPMC_B_TMR_CL = 2;
  localparam int PPMC_B_TMR_CN = 3;
  localparam int PPMC_B_IRQ0   = 4;
  localparam int PPMC_B_RFSH   = 5;
  localparam int PPMC_B_WAIT   = 6;
  localparam int PPMC_B_SYSCLK = 7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PPMC_SINGLE0  = 2'd0,
    PPMC_SINGLE1  = 2'd1,
    PPMC_ROMLESS0 = 2'd2,
    PPMC_ROMLESS1 = 2'd3
  } ppmc_mode_t;

  typedef enum logic [2:0] {
    PPMC_INIT_W0   = 3'b000,
    PPMC_INIT_W1   = 3'b001,
    PPMC_INIT_W2   = 3'b011,
    PPMC_INIT_LOAD = 3'b010,
    PPMC_INIT_DONE = 3'b110
  } ppmc_init_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic        wr;
    logic        rd;
  } ppmc_bus_req_t;

endpackage

// >>> verilog/ppmc_pin_cell.sv
// One pin: input synchroniser and output/enable selection
`timescale 1ns/1ns
module ppmc_pin_cell
  import ppmc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_in,
  input  wire logic impl,
  input  wire logic in_only,
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic fsel,
  input  wire logic ctl_out,
  input  wire logic ctl_oe,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic out_ff;
  logic oe_ff;

  // ****************************************************************
  // Input path
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Only a level seen by both later stages is accepted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff & impl;
    end
  end

  // ****************************************************************
  // Output path
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      // Registered select: the latch drives until the edge after the select lands
      out_ff <= fsel ? ctl_out : latch;
      oe_ff  <= impl & ~in_only & (fsel ? ctl_oe : ~dir);
    end
  end

  assign pin_out = out_ff;
  assign pin_oe  = oe_ff;
  assign level   = level_ff;

endmodule

// >>> verilog/ppmc_port_ctrl.sv
// Port pin and mode control: port registers, pin muxing, port 0 peripheral routing
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
module ppmc_port_ctrl
  import ppmc_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire ppmc_bus_req_t        bus_req,
  output logic [7:0]                rd_data,
  input  wire logic [1:0]           mode_strap,
  output ppmc_mode_t                mode,
  output logic                      init_done,
  input  wire logic [PPMC_NPIN-1:0] pin_in,
  output logic [PPMC_NPIN-1:0]      pin_out,
  output logic [PPMC_NPIN-1:0]      pin_oe,
  input  wire logic [PPMC_NPIN-1:0] periph_out,
  input  wire logic [PPMC_NPIN-1:0] periph_oe,
  output logic [PPMC_NPIN-1:0]      periph_in,
  input  wire logic                 pulse_timer_out_a,
  input  wire logic                 pulse_timer_out_b,
  output logic                      pulse_timer_clear_in,
  output logic                      pulse_timer_count_in,
  output logic [3:0]                ext_irq_in,
  output logic [3:0]                dma_request_in,
  output logic                      nmi_in,
  output logic [7:0]                analog_input,
  input  wire logic                 refresh_request_out,
  input  wire logic                 system_clock_out,
  output logic                      wait_insert_in
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0][7:0]     latch_ff;
  logic [15:0][7:0]     dir_ff;
  logic [15:0][7:0]     fsel_ff;
  logic [7:0]           alt_ff;
  logic [7:0]           rd_data_ff;
  logic [1:0]           strap_s1_ff;
  logic [1:0]           strap_s2_ff;
  logic [1:0]           strap_s3_ff;
  ppmc_init_t           init_ff;
  ppmc_init_t           nxt_init;
  ppmc_mode_t           mode_ff;
  logic [PPMC_NPIN-1:0] periph_in_ff;
  logic                 tmr_clr_ff;
  logic                 tmr_cnt_ff;
  logic [3:0]           irq_ff;
  logic [3:0]           dma_ff;
  logic                 nmi_ff;
  logic [7:0]           ana_ff;
  logic                 wait_ff;

  logic [15:0][7:0]     level;
  logic [PPMC_NPIN-1:0] ctl_out;
  logic [PPMC_NPIN-1:0] ctl_oe;
  logic                 sel_data;
  logic                 sel_dir;
  logic                 sel_fsel;
  logic                 sel_alt;
  logic [3:0]           idx;
  logic                 load_mode;
  ppmc_mode_t           strap_mode;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Registers sit on even byte addresses; an odd byte decodes to nothing
  always_comb begin
    idx      = bus_req.addr[4:1];
    sel_data = (bus_req.addr[31:5] == PPMC_DATA_BASE[31:5]) && !bus_req.addr[0];
    sel_dir  = (bus_req.addr[31:5] == PPMC_DIR_BASE[31:5]) && !bus_req.addr[0];
    sel_fsel = (bus_req.addr[31:5] == PPMC_FSEL_BASE[31:5]) && !bus_req.addr[0];
    sel_alt  = (bus_req.addr == PPMC_ALT0_ADDR);
  end

  // ****************************************************************
  // Operating mode strap
  // ****************************************************************
  // Strap pins are sampled only after reset release, through three stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
      strap_s3_ff <= 2'h0;
    end else begin
      strap_s1_ff <= mode_strap;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
    end
  end

  assign strap_mode = ppmc_mode_t'(strap_s3_ff);
  // A strap that keeps toggling holds the block in the load state
  assign load_mode  = (init_ff == PPMC_INIT_LOAD) && (strap_s2_ff == strap_s3_ff);

  // ****************************************************************
  // Initialisation sequence
  // ****************************************************************
  // W0 to W2 wait out the strap synchroniser before the first compare
  always_comb begin
    nxt_init = init_ff;
    unique case (init_ff)
      PPMC_INIT_W0: begin
        nxt_init = PPMC_INIT_W1;
      end
      PPMC_INIT_W1: begin
        nxt_init = PPMC_INIT_W2;
      end
      PPMC_INIT_W2: begin
        nxt_init = PPMC_INIT_LOAD;
      end
      PPMC_INIT_LOAD: begin
        if (load_mode) begin
          nxt_init = PPMC_INIT_DONE;
        end
      end
      PPMC_INIT_DONE: begin
        nxt_init = PPMC_INIT_DONE;
      end
      default: begin
        nxt_init = PPMC_INIT_W0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_ff <= PPMC_INIT_W0;
    end else begin
      init_ff <= nxt_init;
    end
  end

  // Mode is captured once per reset; later strap changes are ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_ff <= PPMC_SINGLE0;
    end else if (load_mode) begin
      mode_ff <= strap_mode;
    end
  end

  // ****************************************************************
  // Port registers
  // ****************************************************************
  // Byte access uses wmask 8'hff, bit access a one-hot wmask
  // Unimplemented and input-only latch bits stay low, so they never drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_ff <= {PPMC_NPORT{PPMC_LATCH_RST}};
    end else if (bus_req.wr && sel_data) begin
      latch_ff[idx] <= merge(latch_ff[idx], bus_req.wdata, bus_req.wmask)
                       & PPMC_IMPL[idx] & ~PPMC_INONLY[idx];
    end
  end

  // Input-only bits hold their direction at input
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_ff <= {PPMC_NPORT{PPMC_DIR_RST}};
    end else if (bus_req.wr && sel_dir) begin
      dir_ff[idx] <= (merge(dir_ff[idx], bus_req.wdata, bus_req.wmask)
                      & PPMC_IMPL[idx]) | PPMC_INONLY[idx];
    end
  end

  // Bus-pin ports switch to control mode once the strap is known;
  // a software write in that same cycle loses to the strap load.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fsel_ff <= PPMC_FSEL_FIX1;
    end else if (load_mode) begin
      for (int p = 0; p < PPMC_NPORT; p++) begin
        if (strap_mode != PPMC_SINGLE0) begin
          fsel_ff[p] <= fsel_ff[p] | PPMC_BUS_INIT[p];
        end
      end
      if (strap_mode == PPMC_ROMLESS1) begin
        fsel_ff[PPMC_P5] <= fsel_ff[PPMC_P5];
      end
    end else if (bus_req.wr && sel_fsel) begin
      fsel_ff[idx] <= (merge(fsel_ff[idx], bus_req.wdata, bus_req.wmask)
                       & PPMC_FSEL_WR[idx]) | PPMC_FSEL_FIX1[idx];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alt_ff <= PPMC_ALT_RST;
    end else if (bus_req.wr && sel_alt) begin
      alt_ff <= merge(alt_ff, bus_req.wdata, bus_req.wmask) & PPMC_ALT_WR;
    end
  end

  // ****************************************************************
  // Control-mode sources
  // ****************************************************************
  // Other ports take the peripheral buses as given; only ports 0 and X are fixed
  always_comb begin
    ctl_out = periph_out;
    ctl_oe  = periph_oe;
    // Port 0: two timer outputs, the rest are peripheral inputs
    ctl_out[PPMC_B_TMR_A] = pulse_timer_out_a;
    ctl_out[PPMC_B_TMR_B] = pulse_timer_out_b;
    ctl_oe[7:0]           = 8'h03;
    // Port X: refresh request and clock drive, wait is sampled
    ctl_out[120+PPMC_B_RFSH]   = refresh_request_out;
    ctl_out[120+PPMC_B_SYSCLK] = system_clock_out;
    ctl_oe[127:120]            = 8'ha0;
  end

  // ****************************************************************
  // Pin cells
  // ****************************************************************
  // Tie-offs for unimplemented and input-only bits are applied inside each cell
  for (genvar i = 0; i < PPMC_NPIN; i++) begin : g_pin
    ppmc_pin_cell u_cell (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin_in  (pin_in[i]),
      .impl    (PPMC_IMPL[i/8][i%8]),
      .in_only (PPMC_INONLY[i/8][i%8]),
      .latch   (latch_ff[i/8][i%8]),
      .dir     (dir_ff[i/8][i%8]),
      .fsel    (fsel_ff[i/8][i%8]),
      .ctl_out (ctl_out[i]),
      .ctl_oe  (ctl_oe[i]),
      .pin_out (pin_out[i]),
      .pin_oe  (pin_oe[i]),
      .level   (level[i/8][i%8])
    );
  end

  // ****************************************************************
  // Peripheral inputs
  // ****************************************************************
  // A peripheral sees its pin only in control mode, else a steady low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      periph_in_ff <= '0;
    end else begin
      periph_in_ff <= level & fsel_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmr_clr_ff <= 1'b0;
      tmr_cnt_ff <= 1'b0;
      irq_ff     <= 4'h0;
      dma_ff     <= 4'h0;
    end else begin
      tmr_clr_ff <= level[PPMC_P0][PPMC_B_TMR_CL]
                    & fsel_ff[PPMC_P0][PPMC_B_TMR_CL];
      tmr_cnt_ff <= level[PPMC_P0][PPMC_B_TMR_CN] & fsel_ff[PPMC_P0][PPMC_B_TMR_CN];
      // Alternate select only steers pins already in control mode
      irq_ff <= level[PPMC_P0][7:4] & fsel_ff[PPMC_P0][7:4] & ~alt_ff[7:4];
      dma_ff <= level[PPMC_P0][7:4] & fsel_ff[PPMC_P0][7:4] & alt_ff[7:4];
    end
  end

  // ****************************************************************
  // Fixed-function inputs
  // ****************************************************************
  // NMI and analog inputs need no mode bit: always routed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmi_ff  <= 1'b0;
      ana_ff  <= 8'h00;
      wait_ff <= 1'b0;
    end else begin
      nmi_ff  <= level[PPMC_P2][0];
      ana_ff  <= level[PPMC_P7];
      wait_ff <= level[PPMC_PX][PPMC_B_WAIT] & fsel_ff[PPMC_PX][PPMC_B_WAIT];
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  // Data stands only in the cycle after the read strobe
  // Input-only bits read as inputs, so their data is always the pin level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (!bus_req.rd) begin
      rd_data_ff <= 8'h00;
    end else if (sel_data) begin
      rd_data_ff <= ((dir_ff[idx] & level[idx]) | (~dir_ff[idx] & latch_ff[idx]))
                    & PPMC_IMPL[idx];
    end else if (sel_dir) begin
      rd_data_ff <= dir_ff[idx] & PPMC_IMPL[idx];
    end else if (sel_fsel) begin
      rd_data_ff <= fsel_ff[idx];
    end else if (sel_alt) begin
      rd_data_ff <= alt_ff;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Software alone keeps the latch at the idle level before a mode switch;
  // the pin shows the latch value for as long as the select bit is clear.
  assign rd_data              = rd_data_ff;
  assign mode                 = mode_ff;
  assign init_done            = init_ff[2];
  assign periph_in            = periph_in_ff;
  assign pulse_timer_clear_in = tmr_clr_ff;
  assign pulse_timer_count_in = tmr_cnt_ff;
  assign ext_irq_in           = irq_ff;
  assign dma_request_in       = dma_ff;
  assign nmi_in               = nmi_ff;
  assign analog_input         = ana_ff;
  assign wait_insert_in       = wait_ff;

endmodule

// >>> verif/ppmc_far_model.sv
// Board-side pin model for the port pin and mode control block
`timescale 1ns/1ns
module ppmc_far_model
  import ppmc_pkg::*;
(
  input  wire logic [PPMC_NPIN-1:0] pin_out,
  input  wire logic [PPMC_NPIN-1:0] pin_oe,
  input  wire logic [PPMC_NPIN-1:0] board,
  output logic      [PPMC_NPIN-1:0] pin_in
);
  // A driven pin reads back its own drive, a released pin shows the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

// >>> verif/ppmc_port_ctrl_sva.sv
// Port-level assertions for the port pin and mode control block
`timescale 1ns/1ns
module ppmc_port_ctrl_sva
  import ppmc_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire ppmc_bus_req_t        bus_req,
  input wire logic [7:0]           rd_data,
  input wire logic                 init_done,
  input wire logic [PPMC_NPIN-1:0] pin_in,
  input wire logic [PPMC_NPIN-1:0] pin_oe,
  input wire logic [3:0]           ext_irq_in,
  input wire logic [3:0]           dma_request_in,
  input wire logic                 nmi_in,
  input wire logic [7:0]           analog_input
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****
  // Sequences
  // ****
  sequence s_rd(logic [31:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // Seven steady samples out of reset cover the synchroniser plus output stage
  sequence s_nmi_steady;
    ($stable(pin_in[16]) && !rst)[*7];
  endsequence
  sequence s_ana_steady;
    ($stable(pin_in[63:56]) && !rst)[*7];
  endsequence

  // ****
  // Assertions
  // ****
  AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not idle");
  AST_ALT_LOW: assert property (s_rd(PPMC_ALT0_ADDR) |=> rd_data[3:0] == 4'h0)
    else $error("alternate select low bits not zero");
  AST_P2_FSEL: assert property (s_rd(PPMC_FSEL_BASE + 32'h4) |=>
    rd_data[1:0] == 2'b01)
    else $error("port 2 fixed select bits wrong");
  AST_P7_DIR: assert property (s_rd(PPMC_DIR_BASE + 32'he) |=> rd_data == 8'hff)
    else $error("port 7 direction not input");
  AST_PX_DATA: assert property (s_rd(PPMC_DATA_BASE + 32'h1e) |=>
    rd_data[4:0] == 5'h00)
    else $error("port X missing bits not zero");
  AST_INONLY_OE: assert property (pin_oe[63:56] == 8'h00 && !pin_oe[16] &&
    pin_oe[124:120] == 5'h00)
    else $error("input-only pin driven");
  AST_RST_INPUT: assert property ($fell(rst) |-> (pin_oe == '0)[*3])
    else $error("pin driven right after reset");
  AST_INIT: assert property ($fell(rst) |-> (!init_done)[*3] ##[1:4] init_done)
    else $error("strap load timing wrong");
  AST_NMI: assert property (s_nmi_steady |-> nmi_in == pin_in[16])
    else $error("nmi input does not follow pin");
  AST_ANALOG: assert property (s_ana_steady |-> analog_input == pin_in[63:56])
    else $error("analog inputs do not follow pins");
  AST_IRQ_DMA: assert property ((ext_irq_in & dma_request_in) == 4'h0)
    else $error("irq and dma both selected");
endmodule

bind ppmc_port_ctrl ppmc_port_ctrl_sva ppmc_port_ctrl_sva_i (
  .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .init_done(init_done),
  .pin_in(pin_in), .pin_oe(pin_oe), .ext_irq_in(ext_irq_in), .dma_request_in(dma_request_in),
  .nmi_in(nmi_in), .analog_input(analog_input));

// >>> verif/tb.sv
// Register-level testbench for the port pin and mode control block
`timescale 1ns/1ns
module tb;
  import ppmc_pkg::*;
  logic          clk_sys;
  logic          rst;
  ppmc_bus_req_t req;
  logic [7:0]    rd_data;
  logic [1:0]    mode_strap;
  ppmc_mode_t    mode;
  logic          init_done;
  logic [127:0]  pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in, board;
  logic          tmr_a, tmr_b, clr_in, cnt_in, nmi, refresh, sclk, wait_in;
  logic [3:0]    irq, dma;
  logic [7:0]    ana;
  int            n_fail, tests_run, m;

  ppmc_port_ctrl ppmc_port_ctrl_i (.clk_sys(clk_sys), .rst(rst), .bus_req(req),
    .rd_data(rd_data), .mode_strap(mode_strap), .mode(mode), .init_done(init_done),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pulse_timer_out_a(tmr_a),
    .pulse_timer_out_b(tmr_b), .pulse_timer_clear_in(clr_in), .pulse_timer_count_in(cnt_in),
    .ext_irq_in(irq), .dma_request_in(dma), .nmi_in(nmi), .analog_input(ana),
    .refresh_request_out(refresh), .system_clock_out(sclk), .wait_insert_in(wait_in));
  ppmc_far_model ppmc_far_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .board(board),
    .pin_in(pin_in));

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] k);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wmask <= k;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask
  // Pin inputs need four edges to synchronise, peripheral inputs five
  task automatic settle;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset(input logic [1:0] s);
    int i;
    @(posedge clk_sys);
    rst <= 1'b1;
    mode_strap <= s;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 20 && init_done !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(init_done, 1'b1);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****
  // Stimulus
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    mode_strap = 2'h0;
    board = '0;
    periph_out = {16{8'ha5}};
    periph_oe = {16{8'h3c}};
    tmr_a = 1'b0;
    tmr_b = 1'b0;
    refresh = 1'b1;
    sclk = 1'b0;
    n_fail = 0;
    tests_run = 0;
    for (m = 3; m >= 0; m--) begin
      do_reset(m[1:0]);
      chk(mode, m[1:0]);
      rd_chk(PPMC_FSEL_BASE + 32'h8, (m != 0) ? 8'hff : 8'h00);
      rd_chk(PPMC_FSEL_BASE + 32'ha, (m == 1 || m == 2) ? 8'hff : 8'h00);
      rd_chk(PPMC_FSEL_BASE + 32'h10, (m != 0) ? 8'hff : 8'h00);
      rd_chk(PPMC_FSEL_BASE + 32'h1e, (m != 0) ? 8'he0 : 8'h00);
      rd_chk(PPMC_FSEL_BASE, 8'h00);
      rd_chk(PPMC_DIR_BASE, 8'hff);
      rd_chk(PPMC_ALT0_ADDR, 8'h00);
      chk(pin_oe[7:0], 8'h00);
      if (m == 1) begin
        chk(pin_oe[39:32], 8'h3c);
        chk(pin_out[39:32] & 8'h3c, 8'h24);
        chk(pin_oe[127:125], 3'b101);
        chk(pin_out[127:125] & 3'b101, 3'b001);
      end
    end
    $display("test reset_modes done");
    wr(PPMC_DATA_BASE, 8'h5a, 8'hff);
    wr(PPMC_DIR_BASE, 8'h0f, 8'hff);
    @(posedge clk_sys);
    board[7:0] <= 8'hc3;
    settle;
    chk(pin_oe[7:0], 8'hf0);
    chk(pin_out[7:4], 4'h5);
    rd_chk(PPMC_DATA_BASE, 8'h53);
    wr(PPMC_DATA_BASE, 8'hff, 8'h80);
    wr(PPMC_DIR_BASE, 8'h00, 8'h01);
    rd_chk(PPMC_DATA_BASE, 8'hd2);
    rd_chk(PPMC_DIR_BASE, 8'h0e);
    wr(PPMC_DIR_BASE, 8'hff, 8'hff);
    $display("test direction_bits done");
    wr(PPMC_DATA_BASE, 8'h00, 8'h03);
    @(posedge clk_sys);
    tmr_a <= 1'b1;
    board[3:2] <= 2'b10;
    #1;
    chk(pin_out[1:0], 2'b00);
    wr(PPMC_FSEL_BASE, 8'h0f, 8'hff);
    settle;
    chk(pin_oe[1:0], 2'b11);
    chk(pin_out[1:0], 2'b01);
    chk(cnt_in, 1'b1);
    chk(clr_in, 1'b0);
    rd_chk(PPMC_FSEL_BASE, 8'h0f);
    @(posedge clk_sys);
    tmr_a <= 1'b0;
    tmr_b <= 1'b1;
    board[3:2] <= 2'b01;
    settle;
    chk(pin_out[1:0], 2'b10);
    chk(cnt_in, 1'b0);
    chk(clr_in, 1'b1);
    $display("test timer_control done");
    @(posedge clk_sys);
    board[7:4] <= 4'hf;
    wr(PPMC_ALT0_ADDR, 8'hff, 8'hff);
    settle;
    chk(irq, 4'h0);
    chk(dma, 4'h0);
    rd_chk(PPMC_ALT0_ADDR, 8'hf0);
    wr(PPMC_FSEL_BASE, 8'hf0, 8'hf0);
    settle;
    chk(dma, 4'hf);
    chk(irq, 4'h0);
    wr(PPMC_ALT0_ADDR, 8'h50, 8'hff);
    settle;
    chk(dma, 4'h5);
    chk(irq, 4'ha);
    $display("test irq_dma done");
    @(posedge clk_sys);
    board[16] <= 1'b1;
    board[63:56] <= 8'h96;
    board[127:125] <= 3'b101;
    wr(PPMC_DIR_BASE + 32'he, 8'h00, 8'hff);
    wr(PPMC_FSEL_BASE + 32'h4, 8'h00, 8'hff);
    settle;
    chk(nmi, 1'b1);
    chk(ana, 8'h96);
    rd_chk(PPMC_DIR_BASE + 32'he, 8'hff);
    rd_chk(PPMC_FSEL_BASE + 32'h4, 8'h01);
    rd_chk(PPMC_DATA_BASE + 32'h1e, 8'ha0);
    @(posedge clk_sys);
    board[126] <= 1'b1;
    wr(PPMC_FSEL_BASE + 32'h1e, 8'hff, 8'hff);
    settle;
    chk(wait_in, 1'b1);
    chk(periph_in[127:120], 8'h60);
    chk(pin_oe[127:125], 3'b101);
    chk(pin_out[127:125] & 3'b101, 3'b001);
    rd_chk(PPMC_FSEL_BASE + 32'h1e, 8'he0);
    rd_chk(32'hfffff001, 8'h00);
    rd_chk(32'hfffff600, 8'h00);
    $display("test fixed_pins done");
    close_out;
  end
endmodule
